// ### hw/splpi_cfg.svh
// Constants for the speed loop PI block with current limit selection.
// Summary of operation
// - Low limit source: six choices, default stored.
// - Stored high limit clamps output when selected.
// - Stored low limit clamps output when selected.
// - Network words refresh only under active network.
// - Negate enable, default on, negates low limit.
// - Negate on: both stored limits non-negative.
// - Negate off: stored low limit non-positive.
// - Negate enable change raises alarm code.
// - Negate enable change forces selectors stored.
// - Negate enable change negates stored low limit.
// - Low limit range follows negate enable; default 150.
// - Low limit clamped zero for three feedback cases.
// - Stored high limit zero to maximum, default 150.
// - Output is gain times (s plus lead)/s.
// - Network reset control resets the integrator.
// - Stopped drive holds the integrator in reset.
// - Reset output equals preload; resume from it.
// - Reset and preload usable only under network.
// - Non-network control uses preload of zero.
// - Preload select: 0 zero, 1 value, 2 trim.
// - Reset control forced off without network.
// - Stored limits clamped, no non-zero minimum.
`ifndef SPLPI_CFG_SVH
`define SPLPI_CFG_SVH
`define SPLPI_A_CTRL      4'h0
`define SPLPI_A_HI_LIM    4'h1
`define SPLPI_A_LO_LIM    4'h2
`define SPLPI_A_GAIN      4'h3
`define SPLPI_A_LEAD      4'h4
`define SPLPI_A_PRELOAD   4'h5
`define SPLPI_A_OUT       4'h6
`define SPLPI_A_STATUS    4'h7
`define SPLPI_A_MAXCUR    4'h8
`define SPLPI_LIM_DEFAULT 16'h0096
`define SPLPI_MAX_DEFAULT 16'h00C8
`define SPLPI_GAIN_DEFAULT 16'h01B8
`define SPLPI_LEAD_DEFAULT 16'h012C
`define SPLPI_ALARM_CODE  16'h0052
`define SPLPI_GAIN_FRAC   8
`define SPLPI_LEAD_SHIFT  14
`endif

// ### hw/splpi_pkg.sv
// Types for the speed loop PI block.
package splpi_pkg;
  typedef enum logic [2:0] {
    SPLPI_SRC_STORED = 3'h0,
    SPLPI_SRC_AIN1   = 3'h1,
    SPLPI_SRC_AIN2   = 3'h2,
    SPLPI_SRC_NET1   = 3'h3,
    SPLPI_SRC_NET2   = 3'h4,
    SPLPI_SRC_NET3   = 3'h5
  } splpi_src_type;
  typedef enum logic [1:0] {
    SPLPI_PRE_ZERO  = 2'h0,
    SPLPI_PRE_VALUE = 2'h1,
    SPLPI_PRE_TRIM  = 2'h2
  } splpi_pre_type;
  typedef enum logic [1:0] {
    SPLPI_ST_HOLD = 2'b01,
    SPLPI_ST_RUN  = 2'b10
  } splpi_state_type;
  typedef struct packed {
    logic signed [15:0] ain1;
    logic signed [15:0] ain2;
    logic signed [15:0] net1;
    logic signed [15:0] net2;
    logic signed [15:0] net3;
  } splpi_src_words_type;
  typedef struct packed {
    logic network_control;
    logic network_active;
    logic drive_stopped;
    logic regenerative;
    logic ac_tach;
    logic pulse_tach;
    logic encoder_two_phase_enable;
  } splpi_drive_type;
endpackage : splpi_pkg

// ### hw/splpi_core.sv
// Speed loop PI block with selectable current limits and register port.
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "splpi_cfg.svh"
module splpi_core (
  input  wire logic                         mclk,
  input  wire logic                         sys_rst,
  input  wire logic [3:0]                   reg_addr,
  input  wire logic [15:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [15:0]                  reg_rdata,
  input  wire logic                         scan_tick,
  input  wire logic signed [15:0]           speed_error,
  input  wire logic signed [15:0]           manual_trim_ref,
  input  wire splpi_pkg::splpi_src_words_type src_words,
  input  wire splpi_pkg::splpi_drive_type   drive,
  output logic signed [15:0]                current_reference,
  output logic                              limit_alarm
);
  logic [15:0]              ctrl_q;
  logic [15:0]              maxcur_q;
  logic signed [15:0]       hi_lim_q;
  logic signed [15:0]       lo_lim_q;
  logic [15:0]              gain_q;
  logic [15:0]              lead_q;
  logic signed [15:0]       preload_q;
  logic signed [15:0]       net1_q;
  logic signed [15:0]       net2_q;
  logic signed [15:0]       net3_q;
  logic signed [31:0]       integ_q;
  logic                     alarm_q;
  splpi_pkg::splpi_state_type state_q;
  logic signed [15:0]       hi_eff;
  logic signed [15:0]       lo_sel;
  logic signed [15:0]       lo_eff;
  logic signed [15:0]       preload_eff;
  logic                     hold;
  logic                     negate_en;
  logic                     lo_zero;
  logic                     wr_ctrl;
  logic signed [31:0]       prop;
  logic signed [31:0]       integ_next;
  logic signed [31:0]       sum;

  // Control word: [2:0] high source, [5:3] low source, [6] negate enable,
  // [7] integrator reset, [9:8] preload source.
  assign negate_en = ctrl_q[6];
  assign wr_ctrl   = reg_wr && (reg_addr == `SPLPI_A_CTRL);

  // Picks a limit word from one of the six sources.
  function automatic logic signed [15:0] pick(input logic [2:0] s,
                                              input logic signed [15:0] stored);
    case (s)
      splpi_pkg::SPLPI_SRC_STORED: pick = stored;
      splpi_pkg::SPLPI_SRC_AIN1:   pick = src_words.ain1;
      splpi_pkg::SPLPI_SRC_AIN2:   pick = src_words.ain2;
      splpi_pkg::SPLPI_SRC_NET1:   pick = net1_q;
      splpi_pkg::SPLPI_SRC_NET2:   pick = net2_q;
      splpi_pkg::SPLPI_SRC_NET3:   pick = net3_q;
      default:                     pick = stored;
    endcase
  endfunction : pick

  // Clamps a written stored limit into [lo, hi].
  function automatic logic signed [15:0] lim(input logic signed [15:0] v,
                                             input logic signed [15:0] lo,
                                             input logic signed [15:0] hi);
    lim = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : lim

  assign lo_zero = !drive.regenerative || drive.ac_tach ||
                   (drive.pulse_tach && !drive.encoder_two_phase_enable);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_q <= 16'h0040;
    end else if (wr_ctrl) begin
      if (reg_wdata[6] != ctrl_q[6]) begin
        ctrl_q <= {reg_wdata[15:7], reg_wdata[6], 6'h00};
      end else begin
        ctrl_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      maxcur_q <= `SPLPI_MAX_DEFAULT;
      gain_q   <= `SPLPI_GAIN_DEFAULT;
      lead_q   <= `SPLPI_LEAD_DEFAULT;
    end else if (reg_wr) begin
      if (reg_addr == `SPLPI_A_MAXCUR) maxcur_q <= {1'b0, reg_wdata[14:0]};
      if (reg_addr == `SPLPI_A_GAIN) gain_q <= reg_wdata;
      if (reg_addr == `SPLPI_A_LEAD) lead_q <= reg_wdata;
    end
  end

  // Stored limits: written values are clamped into the legal range for the
  // present negate setting, so no non-zero minimum current can arise.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hi_lim_q <= `SPLPI_LIM_DEFAULT;
      lo_lim_q <= `SPLPI_LIM_DEFAULT;
    end else begin
      if (reg_wr && reg_addr == `SPLPI_A_HI_LIM) begin
        hi_lim_q <= lim(reg_wdata, 16'sh0000, maxcur_q);
      end
      if (wr_ctrl && reg_wdata[6] != ctrl_q[6]) begin
        lo_lim_q <= -lo_lim_q;
      end else if (reg_wr && reg_addr == `SPLPI_A_LO_LIM) begin
        if (lo_zero) lo_lim_q <= 16'sh0000;
        else if (negate_en) lo_lim_q <= lim(reg_wdata, 16'sh0000, maxcur_q);
        else lo_lim_q <= lim(reg_wdata, -maxcur_q, 16'sh0000);
      end
    end
  end

  // Sticky alarm; a new change in the same cycle as a clear keeps it set.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      alarm_q <= 1'b0;
    end else if (wr_ctrl && reg_wdata[6] != ctrl_q[6]) begin
      alarm_q <= 1'b1;
    end else if (reg_wr && reg_addr == `SPLPI_A_STATUS && reg_wdata[0]) begin
      alarm_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      net1_q <= 16'sh0000;
      net2_q <= 16'sh0000;
      net3_q <= 16'sh0000;
    end else if (drive.network_control && drive.network_active) begin
      net1_q <= src_words.net1;
      net2_q <= src_words.net2;
      net3_q <= src_words.net3;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) preload_q <= 16'sh0000;
    else if (reg_wr && reg_addr == `SPLPI_A_PRELOAD) preload_q <= reg_wdata;
  end

  always_comb begin
    hi_eff = pick(ctrl_q[2:0], hi_lim_q);
    lo_sel = pick(ctrl_q[5:3], lo_lim_q);
    lo_eff = negate_en ? -lo_sel : lo_sel;
    if (!drive.network_control) begin
      preload_eff = 16'sh0000;
    end else begin
      case (ctrl_q[9:8])
        splpi_pkg::SPLPI_PRE_VALUE: preload_eff = preload_q;
        splpi_pkg::SPLPI_PRE_TRIM:  preload_eff = manual_trim_ref;
        default:                    preload_eff = 16'sh0000;
      endcase
    end
    hold = drive.drive_stopped || (drive.network_control && ctrl_q[7]);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) state_q <= splpi_pkg::SPLPI_ST_HOLD;
    else if (hold) state_q <= splpi_pkg::SPLPI_ST_HOLD;
    else state_q <= splpi_pkg::SPLPI_ST_RUN;
  end

  // Kp*(e + wld*integral e); integrator in units of output, clamped to the same limits.
  always_comb begin
    prop = (32'(speed_error) * $signed({1'b0, gain_q})) >>> `SPLPI_GAIN_FRAC;
    integ_next = integ_q + ((prop * $signed({1'b0, lead_q})) >>> `SPLPI_LEAD_SHIFT);
    if (integ_next > 32'(hi_eff)) integ_next = 32'(hi_eff);
    if (integ_next < 32'(lo_eff)) integ_next = 32'(lo_eff);
    sum = prop + integ_next;
    if (sum > 32'(hi_eff)) sum = 32'(hi_eff);
    if (sum < 32'(lo_eff)) sum = 32'(lo_eff);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      integ_q           <= 32'sh00000000;
      current_reference <= 16'sh0000;
    end else if (state_q == splpi_pkg::SPLPI_ST_HOLD || hold) begin
      integ_q           <= 32'(preload_eff);
      current_reference <= preload_eff;
    end else if (scan_tick) begin
      integ_q           <= integ_next;
      current_reference <= sum[15:0];
    end
  end

  always_ff @(posedge mclk) limit_alarm <= sys_rst ? 1'b0 : alarm_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SPLPI_A_CTRL:    reg_rdata <= ctrl_q;
        `SPLPI_A_HI_LIM:  reg_rdata <= hi_lim_q;
        `SPLPI_A_LO_LIM:  reg_rdata <= lo_lim_q;
        `SPLPI_A_GAIN:    reg_rdata <= gain_q;
        `SPLPI_A_LEAD:    reg_rdata <= lead_q;
        `SPLPI_A_PRELOAD: reg_rdata <= preload_q;
        `SPLPI_A_OUT:     reg_rdata <= current_reference;
        `SPLPI_A_STATUS:  reg_rdata <= alarm_q ? `SPLPI_ALARM_CODE : 16'h0000;
        `SPLPI_A_MAXCUR:  reg_rdata <= maxcur_q;
        default:          reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule : splpi_core

// ### sim/splpi_asserts.sv
// Port checker for the speed loop PI block.
`timescale 1ns/100ps
module splpi_asserts (
  input wire logic                       mclk,
  input wire logic                       sys_rst,
  input wire logic [3:0]                 reg_addr,
  input wire logic [15:0]                reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [15:0]                reg_rdata,
  input wire logic signed [15:0]         current_reference,
  input wire splpi_pkg::splpi_drive_type drive,
  input wire logic                       limit_alarm
);
  logic neg_q;
  wire  tog = reg_wr && reg_addr == 4'h0 && reg_wdata[6] != neg_q;
  wire  clr = reg_wr && reg_addr == 4'h7 && reg_wdata[0];
  // Shadow of the negate enable so that a toggling write can be recognised.
  always_ff @(posedge mclk) begin
    if (sys_rst)
      neg_q <= 1'b1;
    else if (reg_wr && reg_addr == 4'h0)
      neg_q <= reg_wdata[6];
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence clr_quiet;
    clr ##1 !tog;
  endsequence
  sequence stop_local;
    (!drive.network_control && drive.drive_stopped) [*2];
  endsequence
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  a_out_read: assert property (reg_rd && reg_addr == 4'h6 |=>
    reg_rdata == $past(current_reference) || reg_rdata == current_reference)
    else $error("output read wrong");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h8 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_alarm_raise: assert property (tog |-> ##2 limit_alarm)
    else $error("alarm not raised");
  a_alarm_status: assert property (reg_rd && reg_addr == 4'h7 |=>
    (reg_rdata == 16'h0052) == limit_alarm) else $error("status code wrong");
  a_alarm_hold: assert property (limit_alarm && !clr && !$past(clr) |=> limit_alarm)
    else $error("alarm dropped");
  a_alarm_clear: assert property (clr_quiet |=> !limit_alarm)
    else $error("alarm not cleared");
  a_stop_zero: assert property (stop_local |-> current_reference == 16'sh0000)
    else $error("stopped output not zero");
endmodule : splpi_asserts
bind splpi_core splpi_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .current_reference(current_reference), .drive(drive), .limit_alarm(limit_alarm));

// ### sim/splpi_partner.sv
// Far-side model presenting the analog inputs and network input words.
`timescale 1ns/100ps
module splpi_partner (
  input  wire logic                      mclk,
  input  wire logic [79:0]               load,
  output splpi_pkg::splpi_src_words_type src_words
);
  // Words land one clock after the host loads them, like a real transfer.
  always_ff @(posedge mclk) begin
    src_words <= load;
  end
endmodule : splpi_partner

// ### sim/tb_top.sv
// Self-checking bench for the speed loop PI block.
`timescale 1ns/100ps
module tb_top;
  logic mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, scan_tick = 0;
  logic [3:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, v;
  logic signed [15:0] speed_error = 0, manual_trim_ref = 0, current_reference;
  logic [79:0] load = 0;
  splpi_pkg::splpi_src_words_type src_words;
  splpi_pkg::splpi_drive_type drive = 7'b0001000;
  logic limit_alarm;
  int error_cnt = 0, cmp_count = 0, seed = 80684, i;
  always #12.5 mclk = ~mclk;
  splpi_partner u_far (.mclk(mclk), .load(load), .src_words(src_words));
  splpi_core DUT (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scan_tick(scan_tick),
    .speed_error(speed_error), .manual_trim_ref(manual_trim_ref), .src_words(src_words),
    .drive(drive), .current_reference(current_reference), .limit_alarm(limit_alarm));
  function automatic logic [15:0] lim_exp(input logic [15:0] b, input int k, input bit n);
    lim_exp = n ? -(b + 16'(k)) : b + 16'(k);
  endfunction : lim_exp
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge mclk);
    reg_wr <= 0;
    @(posedge mclk);
    // One more edge so that an output launched by the write has settled.
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge mclk);
    reg_rd <= 0;
    #1 chk(reg_rdata, exp);
    @(posedge mclk);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) begin
      scan_tick <= 1;
      @(posedge mclk);
      scan_tick <= 0;
      @(posedge mclk);
    end
  endtask : tick
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 0;
    @(posedge mclk);
    rd(4'h0, 16'h0040);
    rd(4'h1, 16'h0096);
    rd(4'h2, 16'h0096);
    rd(4'h8, 16'h00C8);
    rd(4'hF, 16'h0000);
    wr(4'h2, 16'hFFFB);
    rd(4'h2, 16'h0000);
    wr(4'h1, 16'h0032);
    wr(4'h2, 16'h001E);
    $display("test defaults done");
    drive.network_control <= 1;
    drive.network_active <= 1;
    for (i = 1; i < 6; i++) begin
      v = 16'h0001 + ($random(seed) & 16'h003F);
      load <= {v, v + 16'h1, v + 16'h2, v + 16'h3, v + 16'h4};
      speed_error <= 16'sh1388;
      wr(4'h0, 16'h0040 | 16'(i));
      tick(3);
      chk(current_reference, lim_exp(v, i - 1, 0));
      speed_error <= -16'sh1388;
      wr(4'h0, 16'h0040 | (16'(i) << 3));
      tick(3);
      chk(current_reference, lim_exp(v, i - 1, 1));
    end
    drive.network_active <= 0;
    load <= ~load;
    tick(3);
    chk(current_reference, lim_exp(v, 4, 1));
    $display("test sources done");
    wr(4'h5, 16'h0019);
    wr(4'h0, 16'h01C0);
    chk(current_reference, 16'h0019);
    manual_trim_ref <= -16'sh000C;
    wr(4'h0, 16'h02C0);
    chk(current_reference, 16'hFFF4);
    wr(4'h0, 16'h00C0);
    chk(current_reference, 16'h0000);
    speed_error <= 0;
    wr(4'h0, 16'h01C0);
    wr(4'h0, 16'h0140);
    tick(2);
    chk(current_reference, 16'h0019);
    wr(4'h0, 16'h01C0);
    drive.network_control <= 0;
    speed_error <= 16'sh1388;
    tick(3);
    chk(current_reference, 16'h0032);
    drive.drive_stopped <= 1;
    tick(2);
    chk(current_reference, 16'h0000);
    drive.drive_stopped <= 0;
    $display("test preload done");
    wr(4'h0, 16'h003F);
    rd(4'h0, 16'h0000);
    rd(4'h2, 16'hFFE2);
    rd(4'h7, 16'h0052);
    wr(4'h7, 16'h0001);
    rd(4'h7, 16'h0000);
    speed_error <= -16'sh1388;
    tick(3);
    chk(current_reference, 16'hFFE2);
    wr(4'h2, 16'h000A);
    rd(4'h2, 16'h0000);
    drive.regenerative <= 0;
    wr(4'h2, 16'hFFF6);
    rd(4'h2, 16'h0000);
    $display("test negate done");
    wr(4'h4, 16'h0000);
    drive.drive_stopped <= 1;
    speed_error <= 16'sh0014;
    tick(2);
    drive.drive_stopped <= 0;
    tick(3);
    chk(current_reference, 16'h0022);
    $display("test gain done");
    end_of_test();
  end
endmodule : tb_top
